// ==== sad_decoder.sv ====
// system address decoder: steers processor and downstream cycles to one target
// Notes on behaviour
// - memory above 4 GB claimed locally, writes dropped
// - claimed reads above 4 GB return zeros
// - no memory address above 4 GB goes downstream
// - 4 GB decode space, no cap, no remap
// - compatibility area defaults to hub link
// - low 640 KB always to SDRAM
// - frame buffer: mono bit steers mono range first
// - then internal graphics wins when selected, then VGA enable
// - SYSTEM_MGMT_MODE host cycles to SDRAM when enabled
// - downstream cycles to SYSTEM_MGMT_MODE space: frame buffer
// - mono memory range steered by mono bit
// - mono i/o ports steered like mono range
// - thirteen segments with separate read/write enables
// - expansion range: eight 16 KB segments
// - disabled expansion segment goes to hub link
// - extended BIOS: four 16 KB segments
// - system BIOS segment resets fully disabled
// - independent attributes allow BIOS shadowing
// - 1 MB up to top of memory: SDRAM
// - top of memory to 4 GB: downstream
`timescale 1ns/100ps
module sad_decoder (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// AHB-Lite register slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// cycle to decode and its routing answer
	input  sad_pkg::sad_req_type        cycleReq,
	output sad_pkg::sad_route_type      cycleRoute
);
	import sad_pkg::*;

	// configuration and status state
	logic [CTRL_W-1:0]    ctrl_ff;
	logic [2*SEG_CNT-1:0] segAttr_ff;
	logic [31:0]          topOfMem_ff;
	logic [CNT_W-1:0]     decodeCnt_ff;
	sad_dest_type         lastDest_ff;
	logic                 highSeen_ff;

	// AHB data phase state
	logic        wrPend_ff;
	logic [31:0] wrAddr_ff;
	logic [31:0] hrdata_ff;

	// routing answer
	sad_route_type route_ff;

	wire gfxEnable   = ctrl_ff[CTRL_GFX_BIT];
	wire vgaEnable   = ctrl_ff[CTRL_VGA_BIT];
	wire monoPresent = ctrl_ff[CTRL_MONO_BIT];
	wire smramEnable = ctrl_ff[CTRL_SMM_BIT];

	// cycle address fields
	wire [31:0] addrLo  = cycleReq.addr[31:0];
	wire        above4g = |cycleReq.addr[35:32];
	wire        isMem   = ~cycleReq.io;
	wire        inDos   = isMem & (addrLo < VGA_BASE);
	wire        inVga   = isMem & (addrLo >= VGA_BASE) & (addrLo < EXP_BASE);
	wire        inMono  = isMem & (addrLo >= MONO_BASE) & (addrLo < MONO_END);
	wire        inSeg   = isMem & (addrLo >= EXP_BASE) & (addrLo < EXT_BASE);
	wire        belowTom = addrLo < topOfMem_ff;

	// mono adapter i/o ports, only in the low 64 KB of i/o space
	logic [MONO_IO_CNT-1:0] monoPortHit;
	genvar p;
	generate
		for (p = 0; p < MONO_IO_CNT; p++) begin : g_mono_io
			assign monoPortHit[p] = (addrLo == {16'h0000, MONO_IO[p]});
		end
	endgenerate
	wire monoIo = cycleReq.io & (|monoPortHit);

	// per-segment attribute lookup: even bit read enable, odd bit write enable
	logic [SEG_CNT-1:0] segHit;
	logic [SEG_CNT-1:0] segSdram;
	genvar s;
	generate
		for (s = 0; s < SEG_CNT; s++) begin : g_seg
			localparam logic [31:0] SEG_LO = (s == SEG_CNT - 1) ? BIOS_BASE
				: 32'(EXP_BASE + (32'(s) << SEG_SHIFT));
			localparam logic [31:0] SEG_HI = (s == SEG_CNT - 1) ? EXT_BASE
				: 32'(EXP_BASE + (32'(s + 1) << SEG_SHIFT));
			assign segHit[s]   = inSeg & (addrLo >= SEG_LO) & (addrLo < SEG_HI);
			assign segSdram[s] = segHit[s] & (cycleReq.write ? segAttr_ff[2*s+1]
				: segAttr_ff[2*s]);
		end
	endgenerate

	// frame buffer and mono steering
	wire monoTarget = inMono | monoIo;
	sad_dest_type vgaDest;
	always_comb begin
		if (monoTarget && monoPresent) begin
			vgaDest = DEST_HUB_LINK;
		end else if (gfxEnable) begin
			vgaDest = DEST_GFX;
		end else if (vgaEnable) begin
			vgaDest = DEST_AGP;
		end else begin
			vgaDest = DEST_HUB_LINK;
		end
	end

	// only host cycles in system management mode may reach the hidden SDRAM
	wire smmHit = smramEnable & inVga & cycleReq.sysMgmtMode & (cycleReq.origin == ORG_HOST);

	// single destination, strict priority
	sad_dest_type destNow;
	always_comb begin
		if (above4g && isMem) begin
			destNow = DEST_LOCAL;
		end else if (cycleReq.io) begin
			destNow = monoIo ? vgaDest : DEST_HUB_LINK;
		end else if (inDos) begin
			destNow = DEST_SDRAM;
		end else if (inVga) begin
			destNow = smmHit ? DEST_SDRAM : vgaDest;
		end else if (inSeg) begin
			destNow = (|segSdram) ? DEST_SDRAM : DEST_HUB_LINK;
		end else if (belowTom) begin
			destNow = DEST_SDRAM;
		end else begin
			destNow = DEST_HUB_LINK;
		end
	end

	wire claimLocal = (destNow == DEST_LOCAL);

	// next routing answer; local claims carry no forwarded address
	sad_route_type nxt_route;
	always_comb begin
		nxt_route.valid     = cycleReq.valid;
		nxt_route.dest      = destNow;
		nxt_route.addr      = claimLocal ? 32'h0000_0000 : addrLo;
		nxt_route.zeroData  = claimLocal & ~cycleReq.write;
		nxt_route.dropWrite = claimLocal & cycleReq.write;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			route_ff <= '{valid: 1'b0, dest: DEST_HUB_LINK, addr: 32'h0000_0000,
				zeroData: 1'b0, dropWrite: 1'b0};
		end else begin
			route_ff <= nxt_route;
		end
	end

	assign cycleRoute = route_ff;

	// AHB-Lite slave: zero wait states, always OKAY
	wire addrPhase = hsel & htrans[1] & hready;
	wire takeWrite = addrPhase & hwrite;
	wire takeRead  = addrPhase & ~hwrite;

	wire wrCtrl = wrPend_ff & (wrAddr_ff == ADR_CTRL);
	wire wrSeg  = wrPend_ff & (wrAddr_ff == ADR_SEG);
	wire wrTom  = wrPend_ff & (wrAddr_ff == ADR_TOM);
	wire wrStat = wrPend_ff & (wrAddr_ff == ADR_STAT);

	wire [31:0] statWord = {7'h00, highSeen_ff, 5'h00, lastDest_ff, decodeCnt_ff};

	// unmapped addresses read as zero
	wire [31:0] readMux = (haddr == ADR_CTRL) ? {28'h000_0000, ctrl_ff}
		: (haddr == ADR_SEG)  ? {6'h00, segAttr_ff}
		: (haddr == ADR_TOM)  ? topOfMem_ff
		: (haddr == ADR_STAT) ? statWord
		: 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 32'h0000_0000;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wrPend_ff <= takeWrite;
			wrAddr_ff <= takeWrite ? haddr : wrAddr_ff;
			hrdata_ff <= takeRead ? readMux : 32'h0000_0000;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	// configuration registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_ff     <= CTRL_RST;
			segAttr_ff  <= SEG_RST;
			topOfMem_ff <= TOM_RST;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= hwdata[CTRL_W-1:0];
			end
			if (wrSeg) begin
				segAttr_ff <= hwdata[2*SEG_CNT-1:0];
			end
			if (wrTom) begin
				topOfMem_ff <= hwdata & TOM_MASK;
			end
		end
	end

	// status: counter wraps; the sticky high-address flag is set over clear
	wire highEvent = cycleReq.valid & claimLocal;
	wire highClear = wrStat & hwdata[STAT_HIGH_BIT];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			decodeCnt_ff <= 16'h0000;
			lastDest_ff  <= DEST_HUB_LINK;
			highSeen_ff  <= 1'b0;
		end else begin
			if (cycleReq.valid) begin
				decodeCnt_ff <= CNT_W'(decodeCnt_ff + 1'b1);
				lastDest_ff  <= destNow;
			end
			highSeen_ff <= highEvent | (highSeen_ff & ~highClear);
		end
	end

endmodule

// ==== sad_decoder_properties.sv ====
// port checks of the decoder's cycle routing
`timescale 1ns/100ps
module sad_decoder_properties (
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire sad_pkg::sad_req_type   cycleReq,
	input wire sad_pkg::sad_route_type cycleRoute
);
	import sad_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire reqHigh = cycleReq.valid && !cycleReq.io && cycleReq.addr[35:32] != 4'h0;
	wire reqLow  = cycleReq.valid && cycleReq.addr[35:32] == 4'h0;
	chk_high_local: assert property (reqHigh |=> cycleRoute.dest == DEST_LOCAL && cycleRoute.addr == '0)
		else $error("high cycle not local");
	chk_read_zero: assert property (reqHigh && !cycleReq.write |=> cycleRoute.zeroData && !cycleRoute.dropWrite)
		else $error("high read not zero");
	chk_write_drop: assert property (reqHigh && cycleReq.write |=> cycleRoute.dropWrite && !cycleRoute.zeroData)
		else $error("high write not dropped");
	chk_fwd_addr: assert property (reqLow |=> cycleRoute.addr == $past(cycleReq.addr[31:0]))
		else $error("forwarded address differs");
	chk_dos_sdram: assert property (reqLow && !cycleReq.io && cycleReq.addr < 36'h0_000A_0000 |=>
		cycleRoute.dest == DEST_SDRAM) else $error("low area not sdram");
	chk_route_pulse: assert property (cycleReq.valid |=> cycleRoute.valid)
		else $error("cycle got no route");
	chk_route_idle: assert property ($fell(cycleReq.valid) |=> $fell(cycleRoute.valid))
		else $error("route without cycle");
	chk_io_hub: assert property (cycleReq.valid && cycleReq.io && cycleReq.addr[11:4] != 8'h3B |=>
		cycleRoute.dest == DEST_HUB_LINK) else $error("plain io not to hub link");
	cover property (reqHigh);
	cover property (cycleReq.valid && cycleReq.sysMgmtMode);
	cover property (cycleRoute.valid && cycleRoute.dest == DEST_GFX);
endmodule
bind sad_decoder sad_decoder_properties chk (.clk_sys(clk_sys), .rst(rst), .cycleReq(cycleReq),
	.cycleRoute(cycleRoute));

// ==== sad_decoder_test.sv ====
// self-checking bench of the system address decoder
`timescale 1ns/100ps
module sad_decoder_test;
	import sad_pkg::*;
	logic          clk_sys = 1'b0;
	logic          rst = 1'b1;
	logic          hsel = 1'b0;
	logic [31:0]   haddr = '0;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [31:0]   hwdata = '0;
	logic          hreadyout;
	logic          hresp;
	logic [31:0]   hrdata;
	logic [31:0]   rd;
	sad_req_type   cycleReq;
	sad_route_type cycleRoute;
	int            bad_count = 0;
	int            checks = 0;
	always #20 clk_sys = ~clk_sys;
	sad_decoder dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cycleReq(cycleReq), .cycleRoute(cycleRoute));
	sad_host_model host (.clk_sys(clk_sys), .cycleReq(cycleReq), .cycleRoute(cycleRoute));
	task automatic cmp32(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// f holds system_mgmt_mode, io, write
	task automatic go(input logic [31:0] a, input logic [2:0] f, input sad_dest_type e,
			input sad_origin_type o = ORG_HOST);
		host.issue({4'h0, a}, f[0], f[1], f[2], o);
		cmp32(32'(host.seen.dest), 32'(e));
	endtask
	task automatic t_regs;
		logic [31:0] ra [5] = '{ADR_CTRL, ADR_SEG, ADR_TOM, ADR_STAT, 32'h0000_0010};
		logic [31:0] rv [5] = '{32'h0000_0000, 32'h0000_0000, TOM_RST, 32'h0001_0000, 32'h0000_0000};
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], '0);
			cmp32(rd, rv[i]);
		end
		// zero wait states and an always OKAY response
		cmp32(32'({hreadyout, hresp}), 32'h0000_0002);
		$display("register test done");
	endtask
	task automatic t_high;
		host.issue(36'h1_0000_0000, 1'b0, 1'b0, 1'b0, ORG_HOST);
		cmp32({host.seen.dest, host.seen.zeroData, host.seen.addr[27:0]}, {DEST_LOCAL, 29'h1000_0000});
		host.issue(36'hF_0000_1000, 1'b1, 1'b0, 1'b0, ORG_HOST);
		cmp32({host.seen.dest, host.seen.dropWrite, host.seen.addr[27:0]}, {DEST_LOCAL, 29'h1000_0000});
		go(32'h000A_0010, 3'h0, DEST_HUB_LINK);
		cmp32(host.seen.addr, 32'h000A_0010);
		// three cycles counted, last to hub link, claim flag sticky
		bus(1'b0, ADR_STAT, '0);
		cmp32(rd, 32'h0101_0003);
		bus(1'b1, ADR_STAT, 32'h0100_0000);
		bus(1'b0, ADR_STAT, '0);
		cmp32(rd, 32'h0001_0003);
		$display("high test done");
	endtask
	task automatic t_vga;
		bus(1'b1, ADR_CTRL, 32'h0000_0001);
		for (int i = 0; i < MONO_IO_CNT; i++)
			go({16'h0000, MONO_IO[i]}, 3'h2, DEST_GFX);
		go(32'h0000_03B0, 3'h2, DEST_HUB_LINK);
		go(32'h000A_0000, 3'h1, DEST_GFX);
		bus(1'b1, ADR_CTRL, 32'h0000_0006);
		go(32'h000A_0000, 3'h0, DEST_AGP);
		go(32'h000B_7FFC, 3'h0, DEST_HUB_LINK);
		go(32'h000B_8000, 3'h1, DEST_AGP);
		bus(1'b1, ADR_CTRL, 32'h0000_000A);
		go(32'h000B_0000, 3'h4, DEST_SDRAM);
		go(32'h000B_0000, 3'h0, DEST_AGP);
		go(32'h000A_0000, 3'h4, DEST_AGP, ORG_AGP);
		go(32'h000A_0000, 3'h5, DEST_AGP, ORG_HUB_LINK);
		go(32'h0009_FFFC, 3'h5, DEST_SDRAM);
		$display("steering test done");
	endtask
	task automatic t_seg;
		go(32'h000F_0000, 3'h0, DEST_HUB_LINK);
		go(32'h000F_FFFC, 3'h1, DEST_HUB_LINK);
		bus(1'b1, ADR_SEG, 32'h0200_0000);
		go(32'h000F_0000, 3'h1, DEST_SDRAM);
		go(32'h000F_0000, 3'h0, DEST_HUB_LINK);
		bus(1'b1, ADR_SEG, 32'hFF80_4000);
		bus(1'b0, ADR_SEG, '0);
		cmp32(rd, 32'h0380_4000);
		go(32'h000F_8000, 3'h0, DEST_SDRAM);
		go(32'h000D_C000, 3'h0, DEST_SDRAM);
		go(32'h000D_FFFC, 3'h1, DEST_HUB_LINK);
		go(32'h000D_BFFC, 3'h0, DEST_HUB_LINK);
		go(32'h000E_C000, 3'h1, DEST_SDRAM);
		go(32'h000E_FFFC, 3'h0, DEST_HUB_LINK);
		$display("segment test done");
	endtask
	task automatic t_ext;
		// top of memory rounded down to a 1 MB boundary
		bus(1'b1, ADR_TOM, 32'h002F_FFFF);
		bus(1'b0, ADR_TOM, '0);
		cmp32(rd, 32'h0020_0000);
		go(32'h0010_0000, 3'h1, DEST_SDRAM);
		go(32'h001F_FFFC, 3'h0, DEST_SDRAM);
		go(32'h0020_0000, 3'h0, DEST_HUB_LINK);
		go(32'hFFFF_FFFC, 3'h1, DEST_HUB_LINK);
		$display("extended test done");
	endtask
	task automatic t_rst;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, ADR_STAT, '0);
		cmp32(rd, 32'h0001_0000);
		bus(1'b0, ADR_TOM, '0);
		cmp32(rd, TOM_RST);
		go(32'h000F_0000, 3'h0, DEST_HUB_LINK);
		$display("reset test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_high();
		t_vga();
		t_seg();
		t_ext();
		t_rst();
		test_done();
	end
	// run needs about 130 cycles; this leaves wide margin
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule

// ==== sad_host_model.sv ====
// processor host bus model issuing one decoder cycle per call
`timescale 1ns/100ps
module sad_host_model (
	input  wire logic                   clk_sys,
	output sad_pkg::sad_req_type        cycleReq,
	input  wire sad_pkg::sad_route_type cycleRoute
);
	import sad_pkg::*;
	sad_route_type seen;
	initial cycleReq = '0;
	task automatic issue(input logic [35:0] a, input logic w, io, system_mgmt_mode, input sad_origin_type o);
		@(posedge clk_sys);
		cycleReq <= '{1'b1, a, w, io, system_mgmt_mode, o};
		@(posedge clk_sys);
		cycleReq.valid <= 1'b0;
		// released address flips so a stale value never looks valid
		cycleReq.addr <= ~a;
		#1 seen = cycleRoute;
	endtask
endmodule

// ==== sad_pkg.sv ====
// shared constants and types of the system address decoder
package sad_pkg;

	// register map, byte addresses on the AHB-Lite slave
	localparam logic [31:0] ADR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] ADR_SEG    = 32'h0000_0004;
	localparam logic [31:0] ADR_TOM    = 32'h0000_0008;
	localparam logic [31:0] ADR_STAT   = 32'h0000_000C;

	// control register fields
	localparam int CTRL_GFX_BIT  = 0;
	localparam int CTRL_VGA_BIT  = 1;
	localparam int CTRL_MONO_BIT = 2;
	localparam int CTRL_SMM_BIT  = 3;
	localparam int CTRL_W        = 4;

	// status register fields
	localparam int STAT_CNT_LSB  = 0;
	localparam int STAT_DEST_LSB = 16;
	localparam int STAT_HIGH_BIT = 24;
	localparam int CNT_W         = 16;

	// reset values
	localparam logic [3:0]  CTRL_RST = 4'h0;
	localparam logic [25:0] SEG_RST  = 26'h000_0000;
	localparam logic [31:0] TOM_RST  = 32'h0010_0000;
	localparam logic [31:0] TOM_MASK = 32'hFFF0_0000;

	// compatibility area layout
	localparam logic [31:0] VGA_BASE  = 32'h000A_0000;
	localparam logic [31:0] MONO_BASE = 32'h000B_0000;
	localparam logic [31:0] MONO_END  = 32'h000B_8000;
	localparam logic [31:0] EXP_BASE  = 32'h000C_0000;
	localparam logic [31:0] BIOS_BASE = 32'h000F_0000;
	localparam logic [31:0] EXT_BASE  = 32'h0010_0000;
	localparam int          SEG_SHIFT = 14;
	localparam int          SEG_CNT   = 13;

	// monochrome adapter i/o ports
	localparam int          MONO_IO_CNT = 6;
	localparam logic [15:0] MONO_IO [MONO_IO_CNT] = '{16'h03B4, 16'h03B5, 16'h03B8,
	                                                 16'h03B9, 16'h03BA, 16'h03BF};

	typedef enum logic [2:0] {
		DEST_SDRAM,
		DEST_HUB_LINK,
		DEST_AGP,
		DEST_GFX,
		DEST_LOCAL
	} sad_dest_type;

	typedef enum logic [1:0] {
		ORG_HOST,
		ORG_AGP,
		ORG_HUB_LINK
	} sad_origin_type;

	typedef struct packed {
		logic           valid;
		logic [35:0]    addr;
		logic           write;
		logic           io;
		logic           sysMgmtMode;
		sad_origin_type origin;
	} sad_req_type;

	typedef struct packed {
		logic         valid;
		sad_dest_type dest;
		logic [31:0]  addr;
		logic         zeroData;
		logic         dropWrite;
	} sad_route_type;

endpackage
